/* inc/lhd_pkg.sv */
package lhd_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_STATUS = 8'h48;
  localparam logic [7:0] ADDR_BAUD = 8'h4A;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h4C;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h4D;
  localparam logic [7:0] ADDR_EXT_RX = 8'h4E;
  localparam logic [7:0] ADDR_EXT_TX = 8'h4F;

  // Field positions
  localparam int CR3_LIN_ENABLE = 6;
  localparam int CR3_SLAVE_SELECT = 5;
  localparam int CR3_AUTO_SYNC = 4;
  localparam int CR3_DETECT_METHOD = 3;
  localparam int CR3_IRQ_ENABLE = 2;
  localparam int CR3_SYNC_STATE = 0;
  localparam int CR2_MUTE = 1;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [11:0] RESET_DIVIDER = 12'h000;
  localparam logic [3:0] RESET_FRACTION = 4'h0;

  // Header length codes
  localparam logic [7:0] LEN_AT_BREAK = 8'hFF;
  localparam logic [7:0] LEN_AT_TIMEOUT = 8'h00;

  // Timing, in sample ticks (16 per bit time)
  localparam int OVERSAMPLE = 16;
  localparam int BREAK_BITS = 11;
  localparam int HEADER_MAX_BITS = 57;
  localparam int IDENT_BITS = 10;
  localparam int SYNC_EDGES = 5;
  localparam logic [10:0] BREAK_TICKS = 11'(BREAK_BITS * OVERSAMPLE);
  localparam logic [10:0] HEADER_MAX_TICKS = 11'(HEADER_MAX_BITS * OVERSAMPLE);
  localparam logic [7:0] IDENT_TICKS = 8'(IDENT_BITS * OVERSAMPLE);
  localparam logic [2:0] SYNC_EDGE_LAST = 3'(SYNC_EDGES - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_IDENT} lhd_state_type;

  typedef struct packed {
    logic fall;
    logic breakSeen;
  } lhd_rx_event_type;

endpackage

/* hdl/lhd_baud_gen.sv */
`timescale 1ns/1ns
module lhd_baud_gen #(
  parameter int DIV_WIDTH = 12
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [DIV_WIDTH-1:0] divisor,
  output logic sampleTick
);

  // Divisor is mantissa.fraction in sixteenths of a clock; one tick per divisor
  typedef struct packed {
    logic [DIV_WIDTH:0] acc;
    logic tick;
  } lhd_baud_state_type;

  lhd_baud_state_type r;
  lhd_baud_state_type next_r;
  logic [DIV_WIDTH:0] sum;

  always_comb begin
    next_r = r;
    sum = r.acc + (DIV_WIDTH+1)'(lhd_pkg::OVERSAMPLE);
    next_r.tick = 1'h0;
    if (divisor[DIV_WIDTH-1:4] == '0) begin // RULE10
      // Zero mantissa stops the serial clock altogether
      next_r.acc = '0;
    end else if (sum >= {1'h0, divisor}) begin
      next_r.acc = sum - {1'h0, divisor};
      next_r.tick = 1'h1;
    end else begin
      next_r.acc = sum;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sampleTick = r.tick;

endmodule // lhd_baud_gen

/* hdl/lhd_rx_sampler.sv */
`timescale 1ns/1ns
module lhd_rx_sampler (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rxData,
  input wire logic sampleTick,
  output lhd_pkg::lhd_rx_event_type rxEvent
);

  typedef struct packed {
    logic rxPrev;
    logic [10:0] lowCnt;
    lhd_pkg::lhd_rx_event_type ev;
  } lhd_sampler_state_type;

  lhd_sampler_state_type r;
  lhd_sampler_state_type next_r;

  always_comb begin
    next_r = r;
    next_r.rxPrev = rxData;
    next_r.ev.fall = r.rxPrev & ~rxData;
    next_r.ev.breakSeen = 1'h0;
    if (rxData) begin
      next_r.lowCnt = '0;
    end else if (sampleTick && r.lowCnt != lhd_pkg::BREAK_TICKS) begin
      // Saturates so that one long low level yields one break only
      next_r.lowCnt = r.lowCnt + 11'h001;
      next_r.ev.breakSeen = (r.lowCnt == lhd_pkg::BREAK_TICKS - 11'h001);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{rxPrev: 1'h1, lowCnt: 11'h000, ev: '0};
    end else begin
      r <= next_r;
    end
  end

  assign rxEvent = r.ev;

endmodule // lhd_rx_sampler

/* hdl/lhd_core.sv */
// Function
// RULE1: Enable and slave bits select off, master, slave.
// RULE2: Method bit picks break or identifier detection.
// RULE3: Under mute, method bit also picks wake-up.
// RULE4: Interrupt enable gates header flag to interrupt.
// RULE5: Header flag cleared by status access, then read.
// RULE6: Identifier method needs break, synch, identifier consecutively.
// RULE7: Synch state set on break, cleared after analysis.
// RULE8: Software clearing synch state returns to idle.
// RULE9: Auto sync counts receive falling edges in synch.
// RULE10: Mantissa 01h-FFh divides; 00h stops clock.
// RULE11: Fraction low nibble sixteenths; upper nibble zero.
// RULE12: Fraction written first; mantissa write applies divider.
// RULE13: Zero mantissa in slave stops transmit, receive clocks.
// RULE14: Slave maps divider onto baud, transmit prescaler addresses.
// RULE15: Software avoids bit read-modify-write on divider.
// RULE16: Length readable only slave with autosync or identifier.
// RULE17: Break loads header length with all ones.
// RULE18: Header timeout loads header length with zero.
// RULE19: Length updates with header flag on success.
// RULE20: Length is 57 minus duration, quarter bits.
// RULE21: Writes to header length are ignored.
`timescale 1ns/1ns
module lhd_core (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic rxData,
  input wire logic wakeSelect,
  output logic wakeByIdentifier,
  output logic receiverMute,
  output logic headerIrq,
  output logic linMaster,
  output logic linSlave,
  output logic syncFieldState,
  output logic sampleTick,
  output logic txClockEnable,
  output logic rxClockEnable
);

  typedef struct packed {
    logic linEnable;
    logic slaveSelect;
    logic autoSyncEnable;
    logic headerDetectMethod;
    logic headerIrqEnable;
    logic headerDetectedFlag;
    logic headerError;
    logic mute;
    logic statusArmed;
    logic [3:0] fracPending;
    logic [11:0] divActive;
    logic [7:0] headerLength;
    lhd_pkg::lhd_state_type state;
    logic [2:0] edgeCnt;
    logic [14:0] cycCnt;
    logic identStarted;
    logic [7:0] identTicks;
    logic [10:0] hdrTicks;
    logic [7:0] rdata;
  } lhd_core_state_type;

  lhd_core_state_type r;
  lhd_core_state_type next_r;
  lhd_pkg::lhd_rx_event_type rxEvent;
  logic tick;
  logic slave;
  logic clearFlags;
  logic wakeEvent;
  logic [11:0] measured;

  function automatic logic isSlaveMode(input logic enable, input logic slaveSel);
    return enable & slaveSel; // RULE1
  endfunction

  // Quarter-bit rounding of 57 bit times less the elapsed header
  function automatic logic [7:0] encodeLength(input logic [10:0] ticks);
    logic [11:0] q;
    q = {1'h0, lhd_pkg::HEADER_MAX_TICKS} - {1'h0, ticks} + 12'h002; // RULE20
    return q[9:2];
  endfunction

  lhd_baud_gen #(
    .DIV_WIDTH(12)
  ) u_baud (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .divisor(r.divActive),
    .sampleTick(tick)
  );

  lhd_rx_sampler u_sampler (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .rxData(rxData),
    .sampleTick(tick),
    .rxEvent(rxEvent)
  );

  always_comb begin
    next_r = r;
    next_r.rdata = lhd_pkg::RESET_BYTE;
    slave = isSlaveMode(r.linEnable, r.slaveSelect);
    clearFlags = 1'h0;
    wakeEvent = 1'h0;
    measured = r.cycCnt[14:3];

    // Register reads; data stands for exactly one cycle
    if (regRead) begin
      if (regAddr == lhd_pkg::ADDR_STATUS) begin
        next_r.rdata = {4'h0, r.headerError, 3'h0};
        next_r.statusArmed = 1'h1; // RULE5
      end else if (regAddr == lhd_pkg::ADDR_CTRL_TWO) begin
        next_r.rdata = {6'h00, r.mute, 1'h0};
      end else if (regAddr == lhd_pkg::ADDR_CTRL_THREE) begin
        next_r.rdata = {1'h0, r.linEnable, r.slaveSelect, r.autoSyncEnable,
                        r.headerDetectMethod, r.headerIrqEnable, r.headerDetectedFlag,
                        r.state == lhd_pkg::ST_SYNC};
        clearFlags = r.statusArmed; // RULE5
        next_r.statusArmed = 1'h0;
      end else if (regAddr == lhd_pkg::ADDR_BAUD && slave) begin
        // Reads return the divider in use, which auto sync may have changed
        next_r.rdata = r.divActive[11:4]; // RULE14
      end else if (regAddr == lhd_pkg::ADDR_EXT_RX && slave
                   && (r.autoSyncEnable || r.headerDetectMethod)) begin
        next_r.rdata = r.headerLength; // RULE16
      end else if (regAddr == lhd_pkg::ADDR_EXT_TX && slave) begin
        next_r.rdata = {4'h0, r.divActive[3:0]}; // RULE11
      end
    end

    // Register writes
    if (regWrite) begin
      if (regAddr == lhd_pkg::ADDR_STATUS) begin
        next_r.statusArmed = 1'h1; // RULE5
      end else if (regAddr == lhd_pkg::ADDR_CTRL_TWO) begin
        next_r.mute = regWdata[lhd_pkg::CR2_MUTE];
      end else if (regAddr == lhd_pkg::ADDR_CTRL_THREE) begin
        next_r.linEnable = regWdata[lhd_pkg::CR3_LIN_ENABLE];
        next_r.slaveSelect = regWdata[lhd_pkg::CR3_SLAVE_SELECT];
        next_r.autoSyncEnable = regWdata[lhd_pkg::CR3_AUTO_SYNC];
        next_r.headerDetectMethod = regWdata[lhd_pkg::CR3_DETECT_METHOD];
        next_r.headerIrqEnable = regWdata[lhd_pkg::CR3_IRQ_ENABLE];
        // Flag bit is hardware owned; only a zero on the synch state bit acts
        if (r.state == lhd_pkg::ST_SYNC && !regWdata[lhd_pkg::CR3_SYNC_STATE]) begin
          next_r.state = lhd_pkg::ST_IDLE; // RULE8
        end
      end else if (regAddr == lhd_pkg::ADDR_BAUD && slave) begin
        next_r.divActive = {regWdata, r.fracPending}; // RULE12
      end else if (regAddr == lhd_pkg::ADDR_EXT_TX && slave) begin
        next_r.fracPending = regWdata[3:0]; // RULE11
      end else if (regAddr == lhd_pkg::ADDR_EXT_RX) begin
        // Header length is hardware owned; software writes leave it alone
        next_r.headerLength = r.headerLength; // RULE21
      end
    end

    if (clearFlags) begin
      next_r.headerDetectedFlag = 1'h0;
      next_r.headerError = 1'h0;
    end

    // Header sequencing; hardware sets below take priority over the clear above
    case (r.state)
      lhd_pkg::ST_IDLE: begin
        if (slave && rxEvent.breakSeen) begin
          next_r.state = lhd_pkg::ST_SYNC; // RULE7
          next_r.hdrTicks = lhd_pkg::BREAK_TICKS;
          next_r.edgeCnt = 3'h0;
          next_r.cycCnt = 15'h0000;
          next_r.headerLength = lhd_pkg::LEN_AT_BREAK; // RULE17
          if (!r.headerDetectMethod) begin
            next_r.headerDetectedFlag = 1'h1; // RULE2 RULE6
            wakeEvent = 1'h1;
          end
        end
      end
      lhd_pkg::ST_SYNC: begin
        if (tick) begin
          next_r.hdrTicks = r.hdrTicks + 11'h001;
        end
        if (r.edgeCnt != 3'h0 && r.cycCnt != 15'h7FFF) begin
          next_r.cycCnt = r.cycCnt + 15'h0001;
        end
        if (rxEvent.fall) begin
          next_r.edgeCnt = r.edgeCnt + 3'h1; // RULE9
          if (r.edgeCnt == 3'h0) begin
            // Starts at one so edge one to edge five spans the full count
            next_r.cycCnt = 15'h0001;
          end
          if (r.edgeCnt == lhd_pkg::SYNC_EDGE_LAST) begin
            // Eight bit times span the first to fifth edge: cycles/8 is sixteenths
            if (r.autoSyncEnable && measured[11:4] != 8'h00) begin
              next_r.divActive = measured; // RULE9
            end
            next_r.state = lhd_pkg::ST_IDENT; // RULE7
            next_r.identStarted = 1'h0;
            next_r.identTicks = 8'h00;
          end
        end
      end
      lhd_pkg::ST_IDENT: begin
        if (tick) begin
          next_r.hdrTicks = r.hdrTicks + 11'h001;
          if (r.identStarted) begin
            next_r.identTicks = r.identTicks + 8'h01;
          end
        end
        if (rxEvent.fall && !r.identStarted) begin
          next_r.identStarted = 1'h1;
          next_r.identTicks = 8'h00;
        end
        if (tick && r.identStarted && r.identTicks == lhd_pkg::IDENT_TICKS - 8'h01) begin
          next_r.state = lhd_pkg::ST_IDLE;
          if (r.headerDetectMethod) begin
            next_r.headerDetectedFlag = 1'h1; // RULE6
            next_r.headerLength = encodeLength(r.hdrTicks); // RULE19
            wakeEvent = 1'h1;
          end else if (r.autoSyncEnable) begin
            next_r.headerLength = encodeLength(r.hdrTicks); // RULE19
          end
        end
      end
      default: begin
        next_r.state = lhd_pkg::ST_IDLE;
      end
    endcase

    // A header that outlives 57 bit times is abandoned
    if (r.state != lhd_pkg::ST_IDLE && r.hdrTicks >= lhd_pkg::HEADER_MAX_TICKS) begin
      next_r.state = lhd_pkg::ST_IDLE;
      next_r.headerLength = lhd_pkg::LEN_AT_TIMEOUT; // RULE18
      next_r.headerError = 1'h1;
    end

    // Leaving slave mode drops any header in progress
    if (!slave) begin
      next_r.state = lhd_pkg::ST_IDLE;
    end

    if (slave && r.mute && wakeEvent) begin
      next_r.mute = 1'h0; // RULE3
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{
        linEnable: 1'h0,
        slaveSelect: 1'h0,
        autoSyncEnable: 1'h0,
        headerDetectMethod: 1'h0,
        headerIrqEnable: 1'h0,
        headerDetectedFlag: 1'h0,
        headerError: 1'h0,
        mute: 1'h0,
        statusArmed: 1'h0,
        fracPending: lhd_pkg::RESET_FRACTION,
        divActive: lhd_pkg::RESET_DIVIDER,
        headerLength: lhd_pkg::RESET_BYTE,
        state: lhd_pkg::ST_IDLE,
        edgeCnt: 3'h0,
        cycCnt: 15'h0000,
        identStarted: 1'h0,
        identTicks: 8'h00,
        hdrTicks: 11'h000,
        rdata: lhd_pkg::RESET_BYTE
      };
    end else begin
      r <= next_r;
    end
  end

  assign regRdata = r.rdata;
  assign receiverMute = r.mute;
  assign linMaster = r.linEnable & ~r.slaveSelect; // RULE1
  assign linSlave = isSlaveMode(r.linEnable, r.slaveSelect); // RULE1
  assign syncFieldState = (r.state == lhd_pkg::ST_SYNC); // RULE7
  assign sampleTick = tick; // RULE10
  // Wake choice follows the method bit only while muted in slave mode
  assign wakeByIdentifier = (linSlave && r.mute) ? r.headerDetectMethod : wakeSelect; // RULE3
  assign headerIrq = linSlave & r.headerIrqEnable & r.headerDetectedFlag; // RULE4
  // Gating rather than a real clock switch keeps one clock tree
  assign txClockEnable = ~(linSlave && r.divActive[11:4] == 8'h00); // RULE13
  assign rxClockEnable = ~(linSlave && r.divActive[11:4] == 8'h00); // RULE13

endmodule // lhd_core

/* verif/lhd_core_asserts.sv */
`timescale 1ns/1ns
module lhd_core_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic rxData,
  input wire logic wakeSelect,
  input wire logic wakeByIdentifier,
  input wire logic receiverMute,
  input wire logic headerIrq,
  input wire logic linMaster,
  input wire logic linSlave,
  input wire logic syncFieldState,
  input wire logic sampleTick,
  input wire logic txClockEnable,
  input wire logic rxClockEnable
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  chk_mode_exclusive: assert property (!(linMaster && linSlave))
    else $error("master and slave decoded together");
  chk_clock_gate: assert property (!txClockEnable |-> linSlave && !rxClockEnable)
    else $error("clock gating outside slave mode");
  chk_tick_stop: assert property ((!rxClockEnable) [*3] |-> !sampleTick)
    else $error("sample tick with stopped clock");
  chk_irq_slave: assert property (headerIrq |-> linSlave)
    else $error("header interrupt outside slave mode");
  chk_wake_plain: assert property (!receiverMute |-> wakeByIdentifier == wakeSelect)
    else $error("wake method changed without mute");
  chk_len_hidden: assert property (regRead && regAddr == lhd_pkg::ADDR_EXT_RX && !linSlave
    |=> regRdata == 8'h00) else $error("header length visible outside slave");
  chk_div_hidden: assert property (regRead && !linSlave && (regAddr == lhd_pkg::ADDR_BAUD
    || regAddr == lhd_pkg::ADDR_EXT_TX) |=> regRdata == 8'h00)
    else $error("divider visible outside slave");
  chk_frac_upper: assert property (regRead && regAddr == lhd_pkg::ADDR_EXT_TX
    |=> regRdata[7:4] == 4'h0) else $error("fraction upper nibble not zero");
  chk_sync_abort: assert property (syncFieldState && regWrite && !regWdata[0]
    && regAddr == lhd_pkg::ADDR_CTRL_THREE |=> !syncFieldState)
    else $error("synch state survived software clear");
  chk_irq_hold: assert property (headerIrq && !regWrite
    && !(regRead && regAddr == lhd_pkg::ADDR_CTRL_THREE) |=> headerIrq)
    else $error("header flag dropped without clear sequence");
endmodule // lhd_core_asserts

bind lhd_core lhd_core_asserts u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxData(rxData),
  .wakeSelect(wakeSelect), .wakeByIdentifier(wakeByIdentifier),
  .receiverMute(receiverMute), .headerIrq(headerIrq), .linMaster(linMaster),
  .linSlave(linSlave), .syncFieldState(syncFieldState), .sampleTick(sampleTick),
  .txClockEnable(txClockEnable), .rxClockEnable(rxClockEnable)
);

/* verif/lhd_lin_master_model.sv */
`timescale 1ns/1ns
module lhd_lin_master_model (
  input wire logic ref_clk,
  input wire logic sendHeader,
  input wire logic breakOnly,
  input wire logic [7:0] bitClocks,
  output logic rxData,
  output logic busy
);
  // Break, delimiter, synch frame, identifier frame; bit 0 leaves first
  logic [33:0] frame = 34'h0;
  int left = 0;
  int cnt = 0;
  always @(posedge ref_clk) begin
    if (left == 0 && sendHeader) begin
      frame <= {1'b1, 8'h3A, 2'b01, 8'h55, 2'b01, 13'h0000};
      left <= breakOnly ? 14 : 34;
      cnt <= 0;
    end else if (left != 0) begin
      if (cnt == int'(bitClocks) - 1) begin
        frame <= frame >> 1;
        left <= left - 1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  // Bus has a pull-up, so a released line reads recessive
  assign rxData = busy ? frame[0] : 1'b1;
  assign busy = left != 0;
endmodule // lhd_lin_master_model

/* verif/lhd_core_tb_top.sv */
`timescale 1ns/1ns
module lhd_core_tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic wakeSelect = 1'b0;
  logic sendHeader = 1'b0;
  logic breakOnly = 1'b0;
  logic [7:0] bitClocks = 8'h10;
  logic [7:0] regRdata;
  logic rxData, busy, wakeByIdentifier, receiverMute, headerIrq, linMaster, linSlave;
  logic syncFieldState, sampleTick, txClockEnable, rxClockEnable;
  int failCount = 0;
  int totalChecks = 0;

  lhd_core u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxData(rxData),
    .wakeSelect(wakeSelect), .wakeByIdentifier(wakeByIdentifier),
    .receiverMute(receiverMute), .headerIrq(headerIrq), .linMaster(linMaster),
    .linSlave(linSlave), .syncFieldState(syncFieldState), .sampleTick(sampleTick),
    .txClockEnable(txClockEnable), .rxClockEnable(rxClockEnable)
  );
  lhd_lin_master_model u_master (
    .ref_clk(ref_clk), .sendHeader(sendHeader), .breakOnly(breakOnly),
    .bitClocks(bitClocks), .rxData(rxData), .busy(busy)
  );

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (failCount == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Whole-byte writes only, never bit set or clear on the divider
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
    @(posedge ref_clk);
  endtask

  // Masked look at the status pins, taken mid-cycle so edge updates have landed
  task automatic pins(input logic [7:0] m, input logic [7:0] e);
    @(negedge ref_clk);
    chk(m & {wakeByIdentifier, receiverMute, txClockEnable, rxClockEnable,
      linSlave, linMaster, headerIrq, syncFieldState}, e);
    @(posedge ref_clk);
  endtask

  task automatic waitFor(input int w, input logic lvl, input int lim);
    logic [2:0] s;
    for (int i = 0; i < lim; i++) begin
      @(negedge ref_clk);
      s = {busy, headerIrq, syncFieldState};
      if (s[w] === lvl) break;
    end
    if (s[w] !== lvl) begin
      chk(8'(s[w]), 8'(lvl));
      summarize();
    end else begin
      @(posedge ref_clk);
    end
  endtask

  // Counts sample ticks over a window of n cycles
  task automatic ticks(input int n, input logic [7:0] exp);
    logic [7:0] c;
    c = 8'h00;
    repeat (n) begin
      @(negedge ref_clk);
      c += 8'(sampleTick);
    end
    chk(c, exp);
    @(posedge ref_clk);
  endtask

  task automatic send(input logic brk, input logic [7:0] bc);
    breakOnly <= brk;
    bitClocks <= bc;
    sendHeader <= 1'b1;
    @(posedge ref_clk);
    sendHeader <= 1'b0;
  endtask

  task automatic scReset();
    logic [7:0] a [7] = '{8'h48, 8'h49, 8'h4A, 8'h4C, 8'h4D, 8'h4E, 8'h4F};
    foreach (a[i]) rdc(a[i], 8'h00);
    wr(8'h4A, 8'h05);
    pins(8'h30, 8'h30);
  endtask

  task automatic scModes();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 8'(i) << 5;
      wr(8'h4D, v);
      pins(8'h0C, {4'h0, v[6] & v[5], v[6] & ~v[5], 2'b00});
    end
  endtask

  task automatic scDivider();
    rdc(8'h4A, 8'h00);
    wr(8'h4F, 8'hFF);
    rdc(8'h4F, 8'h00);
    wr(8'h4A, 8'h03);
    rdc(8'h4A, 8'h03);
    rdc(8'h4F, 8'h0F);
    ticks(63, 8'h10);
    wr(8'h4A, 8'h00);
    pins(8'h30, 8'h00);
    ticks(20, 8'h00);
    wr(8'h4D, 8'h70);
    wr(8'h4E, 8'h55);
    rdc(8'h4E, 8'h00);
    wr(8'h4F, 8'h00);
    wr(8'h4A, 8'h01);
  endtask

  task automatic scIdent();
    wr(8'h4D, 8'h6C);
    send(1'b0, 8'h10);
    waitFor(0, 1'b1, 400);
    rdc(8'h4E, 8'hFF);
    pins(8'h02, 8'h00);
    waitFor(1, 1'b1, 600);
    rdc(8'h4E, 8'h5C);
    rdc(8'h4D, 8'h6E);
    pins(8'h02, 8'h02);
    rdc(8'h48, 8'h00);
    rdc(8'h4D, 8'h6E);
    pins(8'h02, 8'h00);
  endtask

  task automatic scAuto();
    wr(8'h4D, 8'h74);
    send(1'b0, 8'h20);
    waitFor(0, 1'b1, 700);
    pins(8'h02, 8'h02);
    rdc(8'h4E, 8'hFF);
    waitFor(0, 1'b0, 1000);
    rdc(8'h4A, 8'h02);
    waitFor(2, 1'b0, 800);
    wr(8'h48, 8'h00);
    rdc(8'h4D, 8'h76);
    pins(8'h02, 8'h00);
    wr(8'h4F, 8'h00);
    wr(8'h4A, 8'h01);
  endtask

  task automatic scAbort();
    wr(8'h4D, 8'h6C);
    send(1'b1, 8'h10);
    waitFor(0, 1'b1, 400);
    wr(8'h4D, 8'h6C);
    pins(8'h01, 8'h00);
    waitFor(2, 1'b0, 300);
    // Long enough to pass the header deadline had the timer kept running
    repeat (900) @(posedge ref_clk);
    rdc(8'h48, 8'h00);
  endtask

  task automatic scWake();
    wakeSelect <= 1'b1;
    wr(8'h4D, 8'h70);
    wr(8'h4C, 8'h02);
    pins(8'hC0, 8'h40);
    send(1'b1, 8'h10);
    waitFor(0, 1'b1, 400);
    pins(8'hC2, 8'h80);
    waitFor(0, 1'b0, 1000);
    rdc(8'h4E, 8'h00);
    rdc(8'h48, 8'h08);
    rdc(8'h4D, 8'h72);
    rdc(8'h48, 8'h00);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    scReset();
    scModes();
    scDivider();
    scIdent();
    scAuto();
    scAbort();
    scWake();
    summarize();
  end
endmodule // lhd_core_tb_top
